// *** hdl/prc_ctrl.sv ***
/*
 Program replacement controller: APB registers, start sequencing,
 loader handshake, result reporting and a masked interrupt.
 Assumes a loader on core_clk that answers each request with one
 result pulse, and a card presence pin from outside the clock domain.
*/
// What this block does
// - Normal end writes completion code 01
// - Failure sets error, code 00 or 01
// - Code 11 write-protect, 12 bad password
// - Codes 21 no card, 22 absent, 23 big
// - Code 31 when other operation busy
// - Error flag set on failed attempt
// - Next start rising edge clears error
// - Start rising edge begins, password permitting
// - Start bit self-clears at end, reset
// - Start bit readable; clear means done
// - Start enabled only by password A5A5
// - Eight-char name; extension appended here
// - Halt program, suspend cycle monitoring
// - First-cycle flag for one scan
`timescale 1ns/100ps
`default_nettype none
module prc_ctrl (
	input wire logic core_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Card presence pin
	input wire logic card_present_pin,
	// System conditions on core_clk
	input wire logic file_op_busy,
	input wire logic prog_write_busy,
	input wire logic mode_change_busy,
	input wire logic write_protect,
	input wire logic scan_end,
	// Loader handshake
	output logic load_req,
	output logic [95:0] load_name,
	input wire logic load_ack,
	input wire logic [2:0] load_result,
	// Program control
	output logic prog_halt,
	output logic cycle_mon_suspend,
	output logic first_cycle_flag,
	output logic irq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	prc_pkg::prc_state_t st_q; // Sequencer state
	logic start_q; // Start bit
	logic err_q; // Error flag
	logic [7:0] code_q; // Completion code
	logic [15:0] pass_q; // Password word
	logic [1:0] irq_stat_q; // Sticky events
	logic [1:0] irq_mask_q; // Event enables
	logic [31:0] prdata_q; // Read data
	logic pready_q; // Access phase answer
	logic pslverr_q; // Unmapped answer
	logic card_s1_q; // Sync stage one
	logic card_s2_q; // Synchronised presence
	logic load_req_q; // Loader request
	logic [95:0] load_name_q; // Name with extension
	logic halt_q; // Program halted
	logic first_q; // First scan flag
	logic irq_q; // Interrupt line
	logic [15:0] name_rd; // Name word read data
	logic [63:0] name_flat; // Whole name
	logic acc_done; // Transfer completes now
	logic wr_now; // Write completes now
	logic rd_now; // Read completes now
	logic hit_name; // Address in name words
	logic start_edge; // Start written low to high
	logic finish; // Operation ends this cycle
	logic [7:0] fin_code; // Code at finish
	logic fin_err; // Error at finish
	logic [1:0] ev_set; // Events this cycle

	// Word index within the name words
	function automatic logic [1:0] name_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - prc_pkg::OFF_NAME0;
		name_idx = d[3:2];
	endfunction

	// Loader result to completion code
	function automatic logic [7:0] res_code(input logic [2:0] r);
		case (r)
			prc_pkg::RES_OK: res_code = prc_pkg::CC_OK;
			prc_pkg::RES_NOFILE: res_code = prc_pkg::CC_NOFILE;
			prc_pkg::RES_BIG: res_code = prc_pkg::CC_BIG;
			prc_pkg::RES_MEMERR: res_code = prc_pkg::CC_MEMERR;
			default: res_code = prc_pkg::CC_FATAL;
		endcase
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign acc_done = psel && penable && pready_q;
	assign wr_now = acc_done && pwrite && !pslverr_q;
	assign rd_now = acc_done && !pwrite && !pslverr_q;
	assign hit_name = (paddr >= prc_pkg::OFF_NAME0) && (paddr <= prc_pkg::OFF_NAME3)
		&& (paddr[1:0] == 2'b00);
	assign start_edge = wr_now && (paddr == prc_pkg::OFF_CTRL)
		&& pwdata[prc_pkg::START_BIT] && !start_q;

	// One wait state: answer on the second access cycle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			pready_q <= 1'b0;
		else
			pready_q <= psel && penable && !pready_q;
	end

	// Read data and error captured in the first access cycle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (psel && penable && !pready_q)
		begin
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			if (paddr == prc_pkg::OFF_CTRL)
			begin
				prdata_q[prc_pkg::START_BIT] <= start_q;
				prdata_q[prc_pkg::ERR_BIT] <= err_q;
				prdata_q[prc_pkg::CODE_LSB +: prc_pkg::CODE_W] <= code_q;
			end
			else if (paddr == prc_pkg::OFF_PASS)
				prdata_q[15:0] <= pass_q;
			else if (hit_name)
				prdata_q[15:0] <= name_rd;
			else if (paddr == prc_pkg::OFF_IRQ_STAT)
				prdata_q[1:0] <= irq_stat_q;
			else if (paddr == prc_pkg::OFF_IRQ_MASK)
				prdata_q[1:0] <= irq_mask_q;
			else if (paddr == prc_pkg::OFF_STATUS)
				prdata_q[4:0] <= {first_q, halt_q, load_req_q, card_s2_q, st_q != prc_pkg::ST_IDLE};
			else
				// Unmapped address
				pslverr_q <= 1'b1;
		end
		else
			// Error flag stands only beside pready
			pslverr_q <= 1'b0;
	end

	// ----------------------------------------
	// Name words
	// ----------------------------------------
	// name storage
	prc_name_regs #(
		.WORDS(4)
	) u_name (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr_en(wr_now && hit_name),
		.wr_idx(name_idx(paddr)),
		.wr_data(pwdata[15:0]),
		.rd_idx(name_idx(paddr)),
		.rd_data_q(name_rd),
		.name_flat(name_flat)
	);

	// Password word, software owned
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			pass_q <= prc_pkg::PASS_RESET;
		else if (wr_now && paddr == prc_pkg::OFF_PASS)
			pass_q <= pwdata[15:0];
	end

	// ----------------------------------------
	// Card presence synchroniser
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			card_s1_q <= 1'b0;
			card_s2_q <= 1'b0;
		end
		else
		begin
			card_s1_q <= card_present_pin;
			card_s2_q <= card_s1_q;
		end
	end

	// ----------------------------------------
	// Result selection
	// ----------------------------------------
	always_comb
	begin
		finish = 1'b0;
		fin_err = 1'b1;
		fin_code = prc_pkg::CC_FATAL;
		case (st_q)
			prc_pkg::ST_CHECK:
			begin
				finish = 1'b1;
				if (pass_q != prc_pkg::PASS_ENABLE)
					fin_code = prc_pkg::CC_PASS;
				else if (file_op_busy || prog_write_busy || mode_change_busy)
					fin_code = prc_pkg::CC_BUSY;
				else if (write_protect)
					fin_code = prc_pkg::CC_WPROT;
				else if (!card_s2_q)
					fin_code = prc_pkg::CC_NOCARD;
				else
					// Checks passed, go load
					finish = 1'b0;
			end
			prc_pkg::ST_LOAD:
			begin
				finish = load_ack;
				fin_code = res_code(load_result);
				fin_err = (load_result != prc_pkg::RES_OK);
			end
			default:
			begin
				finish = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			st_q <= prc_pkg::ST_IDLE;
		else
		begin
			case (st_q)
				prc_pkg::ST_IDLE:
					if (start_edge)
						st_q <= prc_pkg::ST_CHECK;
				prc_pkg::ST_CHECK:
					if (finish)
						st_q <= prc_pkg::ST_IDLE;
					else
						st_q <= prc_pkg::ST_LOAD;
				prc_pkg::ST_LOAD:
					if (finish && fin_err)
						st_q <= prc_pkg::ST_IDLE;
					else if (finish)
						st_q <= prc_pkg::ST_RESUME;
				prc_pkg::ST_RESUME:
					st_q <= prc_pkg::ST_IDLE;
				default:
					st_q <= prc_pkg::ST_IDLE;
			endcase
		end
	end

	// Start bit: set by software edge, cleared at finish
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			start_q <= 1'b0;
		else if (finish)
			start_q <= 1'b0;
		else if (start_edge && st_q == prc_pkg::ST_IDLE)
			start_q <= 1'b1;
		else if (wr_now && paddr == prc_pkg::OFF_CTRL && st_q == prc_pkg::ST_IDLE)
			start_q <= pwdata[prc_pkg::START_BIT];
	end

	// Error flag and completion code
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			err_q <= 1'b0;
			code_q <= prc_pkg::CODE_RESET;
		end
		else if (finish)
		begin
			err_q <= fin_err;
			code_q <= fin_code;
		end
		else if (start_edge && st_q == prc_pkg::ST_IDLE)
			err_q <= 1'b0;
	end

	// ----------------------------------------
	// Loader handshake
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			load_req_q <= 1'b0;
			load_name_q <= 96'h0;
		end
		else if (st_q == prc_pkg::ST_CHECK && !finish)
		begin
			load_req_q <= 1'b1;
			load_name_q <= {name_flat, prc_pkg::OBJ_EXT};
		end
		else if (st_q == prc_pkg::ST_LOAD && load_ack)
			load_req_q <= 1'b0;
	end

	// ----------------------------------------
	// Program execution control
	// ----------------------------------------
	// halt during load
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			halt_q <= 1'b0;
		else if (st_q == prc_pkg::ST_CHECK && !finish)
			halt_q <= 1'b1;
		else if (st_q == prc_pkg::ST_LOAD && finish)
			halt_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			first_q <= 1'b0;
		else if (st_q == prc_pkg::ST_RESUME)
			first_q <= 1'b1;
		else if (scan_end)
			first_q <= 1'b0;
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign ev_set[prc_pkg::IRQ_OK] = finish && !fin_err;
	assign ev_set[prc_pkg::IRQ_ERR] = finish && fin_err;

	// Sticky status; a read clears only the bits it returned, a new event wins
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			irq_stat_q <= 2'b00;
		else if (rd_now && paddr == prc_pkg::OFF_IRQ_STAT)
			irq_stat_q <= (irq_stat_q & ~prdata_q[1:0]) | ev_set;
		else
			irq_stat_q <= irq_stat_q | ev_set;
	end

	// Mask register
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			irq_mask_q <= 2'b00;
		else if (wr_now && paddr == prc_pkg::OFF_IRQ_MASK)
			irq_mask_q <= pwdata[1:0];
	end

	// Level interrupt, registered
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign load_req = load_req_q;
	assign load_name = load_name_q;
	assign prog_halt = halt_q;
	assign cycle_mon_suspend = halt_q;
	assign first_cycle_flag = first_q;
	assign irq = irq_q;
endmodule // prc_ctrl
`default_nettype wire

// *** hdl/prc_pkg.sv ***
/*
 Constants for the program replacement controller: register offsets,
 control word fields, completion codes and reset values.
 Assumes nothing of its surroundings.
*/
package prc_pkg;
	// ----------------------------------------
	// Register byte offsets on APB
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PASS = 8'h04;
	localparam logic [7:0] OFF_NAME0 = 8'h08;
	localparam logic [7:0] OFF_NAME3 = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	// ----------------------------------------
	// Control word fields
	// ----------------------------------------
	localparam int CODE_LSB = 0;
	localparam int CODE_W = 8;
	localparam int ERR_BIT = 14;
	localparam int START_BIT = 15;
	// ----------------------------------------
	// Password and name padding
	// ----------------------------------------
	localparam logic [15:0] PASS_ENABLE = 16'ha5a5;
	localparam logic [15:0] PASS_RESET = 16'h0000;
	localparam logic [15:0] NAME_RESET = 16'h2020;
	// Object file extension appended to the name
	localparam logic [31:0] OBJ_EXT = 32'h2e4f424a;
	// ----------------------------------------
	// Completion codes
	// ----------------------------------------
	localparam logic [7:0] CC_OK = 8'h01;
	localparam logic [7:0] CC_FATAL = 8'h00;
	localparam logic [7:0] CC_MEMERR = 8'h01;
	localparam logic [7:0] CC_WPROT = 8'h11;
	localparam logic [7:0] CC_PASS = 8'h12;
	localparam logic [7:0] CC_NOCARD = 8'h21;
	localparam logic [7:0] CC_NOFILE = 8'h22;
	localparam logic [7:0] CC_BIG = 8'h23;
	localparam logic [7:0] CC_BUSY = 8'h31;
	localparam logic [7:0] CODE_RESET = 8'h00;
	// ----------------------------------------
	// Loader result encodings
	// ----------------------------------------
	localparam logic [2:0] RES_OK = 3'h0;
	localparam logic [2:0] RES_NOFILE = 3'h1;
	localparam logic [2:0] RES_BIG = 3'h2;
	localparam logic [2:0] RES_FATAL = 3'h3;
	localparam logic [2:0] RES_MEMERR = 3'h4;
	// ----------------------------------------
	// Interrupt status bits
	// ----------------------------------------
	localparam int IRQ_W = 2;
	localparam int IRQ_OK = 0;
	localparam int IRQ_ERR = 1;
	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_LOAD, ST_RESUME} prc_state_t;
endpackage

// *** hdl/prc_name_regs.sv ***
/*
 Four file name words: one write port, a registered read port and
 the whole name as a flat vector.
 Assumes writes and read index come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module prc_name_regs #(
	parameter int WORDS = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [15:0] rd_data_q,
	output logic [16*WORDS-1:0] name_flat
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [15:0] mem_q [WORDS];

	// Word writes; reset fills with spaces
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < WORDS; i++)
				mem_q[i] <= prc_pkg::NAME_RESET;
		end
		else if (wr_en)
		begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	// Registered read data
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rd_data_q <= prc_pkg::NAME_RESET;
		else
			rd_data_q <= mem_q[rd_idx];
	end

	// First word in the top bits, as stored
	always_comb
	begin
		for (int i = 0; i < WORDS; i++)
			name_flat[16*(WORDS-1-i) +: 16] = mem_q[i];
	end
endmodule // prc_name_regs
`default_nettype wire

// *** tb/prc_card_model.sv ***
/*
 Behavioural card loader that answers each load request once.
 Assumes the core_clk domain and one request at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module prc_card_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic load_req,
	input wire logic [7:0] load_delay,
	input wire logic [2:0] load_res,
	output logic load_ack,
	output logic [2:0] load_result
);
	// Cycles spent on the current load
	logic [7:0] cnt_q;
	// Count, answer once; result toggles so stale values never match
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 8'h00;
			load_ack <= 1'b0;
			load_result <= 3'h0;
		end
		else
		begin
			load_ack <= 1'b0;
			load_result <= ~load_result;
			if (!load_req || load_ack)
				cnt_q <= 8'h00;
			else if (cnt_q == load_delay)
			begin
				load_ack <= 1'b1;
				load_result <= load_res;
			end
			else
				cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule // prc_card_model
`default_nettype wire

// *** tb/prc_ctrl_props.sv ***
/*
 Port checker for the replacement controller.
 Assumes it is bound into prc_ctrl on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module prc_ctrl_props (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic file_op_busy,
	input wire logic prog_write_busy,
	input wire logic mode_change_busy,
	input wire logic write_protect,
	input wire logic scan_end,
	input wire logic load_req,
	input wire logic load_ack,
	input wire logic [2:0] load_result,
	input wire logic prog_halt,
	input wire logic cycle_mon_suspend,
	input wire logic first_cycle_flag
);
	// ----------------------------------------
	// Bus timing
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_wait; psel && penable && !$past(penable) |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("pready late");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready too long");
	property p_unmap; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("bad unmapped read");
	// ----------------------------------------
	// Load sequencing
	// ----------------------------------------
	property p_halt; load_req |-> prog_halt && cycle_mon_suspend; endproperty
	a_halt: assert property (p_halt) else $error("program not halted");
	property p_hold; load_req && !load_ack |=> load_req; endproperty
	a_hold: assert property (p_hold) else $error("load dropped early");
	property p_end; load_req && load_ack |=> !load_req && !prog_halt; endproperty
	a_end: assert property (p_end) else $error("load did not end");
	property p_guard;
		$rose(load_req) |->
			!$past(file_op_busy || prog_write_busy || mode_change_busy || write_protect);
	endproperty
	a_guard: assert property (p_guard) else $error("load while blocked");
	property p_fcsrc;
		$rose(first_cycle_flag) |-> $past(load_ack, 2) && $past(load_result, 2) == 3'h0;
	endproperty
	a_fcsrc: assert property (p_fcsrc) else $error("stray first cycle");
	property p_fcend; first_cycle_flag && scan_end |=> !first_cycle_flag; endproperty
	a_fcend: assert property (p_fcend) else $error("first cycle too long");
endmodule // prc_ctrl_props
bind prc_ctrl prc_ctrl_props prc_ctrl_props_inst (.core_clk, .nrst, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .file_op_busy, .prog_write_busy,
	.mode_change_busy, .write_protect, .scan_end, .load_req, .load_ack,
	.load_result, .prog_halt, .cycle_mon_suspend, .first_cycle_flag);
`default_nettype wire

// *** tb/tb_prc_ctrl.sv ***
/*
 Self-checking bench for the replacement controller over APB.
 Assumes prc_ctrl, prc_card_model and the checker are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_prc_ctrl;
	logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic card_present_pin, file_op_busy, prog_write_busy, mode_change_busy;
	logic write_protect, scan_end, load_req, load_ack, prog_halt;
	logic cycle_mon_suspend, first_cycle_flag, irq;
	logic [95:0] load_name;
	logic [2:0] load_result, ld_res;
	logic [7:0] ld_delay;
	int n_fail, cmp_count;
	// Error cases: code, loader result, flags {badpass,nocard,wp,mode,prog,file}
	logic [19:0] err_tbl [10] = '{20'h12020, 20'h31001, 20'h31002, 20'h31004,
		20'h11008, 20'h21010, 20'h22100, 20'h23200, 20'h00300, 20'h01400};
	prc_ctrl prc_ctrl_inst (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .card_present_pin, .file_op_busy,
		.prog_write_busy, .mode_change_busy, .write_protect, .scan_end,
		.load_req, .load_name, .load_ack, .load_result, .prog_halt,
		.cycle_mon_suspend, .first_cycle_flag, .irq);
	prc_card_model prc_card_model_inst (.core_clk, .nrst, .load_req,
		.load_delay(ld_delay), .load_res(ld_res), .load_ack, .load_result);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic stop_test();
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		logic got;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		got = (pready === 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
		if (!got)
		begin
			chk(32'h0, 32'h1);
			stop_test();
		end
	endtask
	// Poll the start bit until it clears
	task automatic wait_done();
		int k;
		k = 0;
		do
		begin
			apb(prc_pkg::OFF_CTRL, 1'b0, 32'h0);
			k++;
		end
		while (rd[15] !== 1'b0 && k < 60);
		if (rd[15] !== 1'b0)
		begin
			chk(rd, 32'h0);
			stop_test();
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		apb(prc_pkg::OFF_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(prc_pkg::OFF_PASS, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(prc_pkg::OFF_NAME0, 1'b0, 32'h0);
		chk(rd, 32'h2020);
		apb(8'h40, 1'b0, 32'h0);
		chk({31'h0, perr}, 32'h1);
		apb(prc_pkg::OFF_IRQ_MASK, 1'b1, 32'h3);
		apb(prc_pkg::OFF_IRQ_MASK, 1'b0, 32'h0);
		chk(rd, 32'h3);
		apb(prc_pkg::OFF_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h2);
	endtask
	task automatic t_codes();
		logic [19:0] e;
		for (int i = 0; i < 10; i++)
		begin
			e = err_tbl[i];
			file_op_busy <= e[0];
			prog_write_busy <= e[1];
			mode_change_busy <= e[2];
			write_protect <= e[3];
			card_present_pin <= ~e[4];
			ld_res <= e[10:8];
			apb(prc_pkg::OFF_PASS, 1'b1, e[5] ? 32'h1234 : 32'ha5a5);
			apb(prc_pkg::OFF_CTRL, 1'b1, 32'h8000);
			wait_done();
			chk(rd, {16'h0, 8'h40, e[19:12]});
			chk({31'h0, irq}, 32'h1);
			apb(prc_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
			chk(rd, 32'h2);
			apb(prc_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		{file_op_busy, prog_write_busy, mode_change_busy, write_protect} <= 4'h0;
		card_present_pin <= 1'b1;
		ld_res <= 3'h0;
	endtask
	task automatic t_ok();
		logic [15:0] nm [4] = '{16'h4142, 16'h4320, 16'h2020, 16'h2020};
		for (int i = 0; i < 4; i++)
			apb(prc_pkg::OFF_NAME0 + 8'(i * 4), 1'b1, {16'h0, nm[i]});
		ld_delay <= 8'h28;
		apb(prc_pkg::OFF_IRQ_MASK, 1'b1, 32'h2);
		apb(prc_pkg::OFF_PASS, 1'b1, 32'ha5a5);
		apb(prc_pkg::OFF_CTRL, 1'b1, 32'h8000);
		apb(prc_pkg::OFF_CTRL, 1'b0, 32'h0);
		chk({30'h0, rd[15:14]}, 32'h2);
		chk({30'h0, prog_halt, cycle_mon_suspend}, 32'h3);
		chk(load_name[95:64], 32'h41424320);
		chk(load_name[63:32], 32'h20202020);
		chk(load_name[31:0], 32'h2e4f424a);
		apb(prc_pkg::OFF_CTRL, 1'b1, 32'h0);
		apb(prc_pkg::OFF_CTRL, 1'b0, 32'h0);
		chk({31'h0, rd[15]}, 32'h1);
		wait_done();
		chk(rd, 32'h0001);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, first_cycle_flag}, 32'h1);
		scan_end <= 1'b1;
		@(posedge core_clk);
		scan_end <= 1'b0;
		@(posedge core_clk);
		chk({31'h0, first_cycle_flag}, 32'h0);
		apb(prc_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
		chk(rd, 32'h1);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		{psel, penable, pwrite, perr, scan_end} = 5'h0;
		{file_op_busy, prog_write_busy, mode_change_busy, write_protect} = 4'h0;
		card_present_pin = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		rd = 32'h0;
		ld_delay = 8'h05;
		ld_res = 3'h0;
		n_fail = 0;
		cmp_count = 0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_codes();
		t_ok();
		stop_test();
	end
endmodule // tb_prc_ctrl
`default_nettype wire
